/* File: lcs_cell_top.sv */
// Logic cell storage elements, control mapping and register slave
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module lcs_cell_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write channels
  input wire logic [lcs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lcs_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read channels
  input wire logic [lcs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [lcs_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Cell inputs
  input wire logic [3:0] cell_ctrl_pins,
  input wire logic [3:0] f_gen_addr,
  input wire logic [3:0] g_gen_addr,
  input wire logic global_init_pin,
  // Cell outputs
  output logic first_registered_out,
  output logic second_registered_out,
  output logic f_gen_out,
  output logic g_gen_out,
  output logic h_gen_out,
  output logic global_init_net
);
  import lcs_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
    pick4 = v[s];
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge_strb = r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic [31:0] cfg_q;
  logic [31:0] map_q;
  logic [31:0] init_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] stat_w;
  logic [31:0] lut_w;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  logic do_write;
  logic aw_take;
  logic w_take;
  logic ar_take;

  lcs_lut_if lut_if ();

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_hit = awaddr_q == OFF_CFG || awaddr_q == OFF_MAP ||
                  awaddr_q == OFF_LUT || awaddr_q == OFF_INIT;
  assign lut_w = {lut_if.g_bits, lut_if.f_bits};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Configuration words; status offset is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
      map_q <= MAP_RESET;
      init_q <= INIT_RESET;
    end else if (do_write) begin
      if (awaddr_q == OFF_CFG) begin
        cfg_q <= merge_strb(cfg_q, wdata_q, wstrb_q) & CFG_MASK;
      end
      if (awaddr_q == OFF_MAP) begin
        map_q <= merge_strb(map_q, wdata_q, wstrb_q) & MAP_MASK;
      end
      if (awaddr_q == OFF_INIT) begin
        init_q <= merge_strb(init_q, wdata_q, wstrb_q) & INIT_MASK;
      end
    end
  end

  assign lut_if.sw_we = do_write && awaddr_q == OFF_LUT;
  assign lut_if.sw_wdata = merge_strb(lut_w, wdata_q, wstrb_q);

  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = s_axi_araddr == OFF_CFG || s_axi_araddr == OFF_MAP ||
                  s_axi_araddr == OFF_LUT || s_axi_araddr == OFF_INIT ||
                  s_axi_araddr == OFF_STAT;
  assign rd_mux = s_axi_araddr == OFF_CFG ? cfg_q :
                  s_axi_araddr == OFF_MAP ? map_q :
                  s_axi_araddr == OFF_LUT ? lut_w :
                  s_axi_araddr == OFF_INIT ? init_q :
                  s_axi_araddr == OFF_STAT ? stat_w : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////
  // Control pin mapping and mode decode

  logic [3:0] int_ctl;
  logic ec;
  logic mem_mode;
  logic sr_h0;
  logic din_h2;
  logic h1_d1;
  lcs_ram_mode_t ram_mode;
  lcs_ram_org_t ram_org;
  logic org32;
  logic dual;
  logic ram_wr;

  for (genvar k = 0; k < 4; k++) begin : g_map
    assign int_ctl[k] = pick4(cell_ctrl_pins, map_q[2*k +: 2]);
  end

  // Same pins, two meanings depending on mode
  assign ec = int_ctl[MAP_EC];
  assign sr_h0 = int_ctl[MAP_SR];
  assign din_h2 = int_ctl[MAP_DIN];
  assign h1_d1 = int_ctl[MAP_H1];
  assign mem_mode = cfg_q[CFG_MEM];
  assign ram_mode = lcs_ram_mode_t'(cfg_q[CFG_RAM_MODE +: 2]);
  assign ram_org = lcs_ram_org_t'(cfg_q[CFG_RAM_ORG +: 2]);
  assign dual = ram_mode == RAM_DUAL || ram_org == ORG_16X1;
  assign org32 = ram_org == ORG_32X1 && !dual;
  // Level mode writes while enable is high, ignoring clock enable
  assign ram_wr = mem_mode && sr_h0 &&
                  (ram_mode == RAM_LEVEL || ec);

  //////////////////////////////////////////////////////////////////////
  // Lookup tables as logic or memory

  // Dual port mirrors every write into G, read through its own address
  assign lut_if.f_addr = f_gen_addr;
  assign lut_if.g_addr = (mem_mode && (org32 || dual)) ? f_gen_addr : g_gen_addr;
  assign lut_if.we_f = ram_wr && !(org32 && h1_d1);
  assign lut_if.we_g = ram_wr && (!org32 || h1_d1);
  assign lut_if.wd_f = din_h2;
  assign lut_if.wd_g = (org32 || dual) ? din_h2 : h1_d1;

  lcs_lut_ram u_lut (
    .aclk(aclk),
    .aresetn(aresetn),
    .lut(lut_if.mem)
  );

  logic dp_read;
  assign dp_read = g_gen_addr == f_gen_addr ? lut_if.g_rd : lut_if.g_bits[g_gen_addr];
  assign f_gen_out = (mem_mode && org32 && h1_d1) ? lut_if.g_rd : lut_if.f_rd;
  assign g_gen_out = (mem_mode && dual) ? dp_read : lut_if.g_rd;
  assign h_gen_out = init_q[INIT_HTAB + {din_h2, h1_d1, sr_h0}];

  //////////////////////////////////////////////////////////////////////
  // Global init net

  lcs_gsrc_t gsrc;
  logic gsr_pin_path;
  assign gsrc = lcs_gsrc_t'(init_q[INIT_SRC +: 2]);
  assign gsr_pin_path = global_init_pin ^ init_q[INIT_INV];
  assign global_init_net = init_q[INIT_SW] ||
                           (gsrc == GSRC_PIN ? gsr_pin_path :
                            gsrc == GSRC_F ? f_gen_out :
                            gsrc == GSRC_G ? g_gen_out : h_gen_out);

  //////////////////////////////////////////////////////////////////////
  // Storage elements, index 0 feeds first output, 1 the second

  logic [1:0] st_q;
  logic [1:0] st_d;
  logic [1:0] st_vis;
  logic [1:0] st_din;
  logic [1:0] sr_local;
  logic [1:0] force_init;
  logic [1:0] set_cfg;
  logic [1:0] reg_out;

  for (genvar i = 0; i < 2; i++) begin : g_st
    lcs_dsel_t dsel;
    assign dsel = lcs_dsel_t'(cfg_q[CFG_DSEL + 2*i +: 2]);
    assign set_cfg[i] = cfg_q[CFG_SET + i];
    assign st_din[i] = dsel == DSEL_F ? f_gen_out :
                       dsel == DSEL_G ? g_gen_out :
                       dsel == DSEL_H ? h_gen_out : din_h2;
    // Local pin is the write enable in memory mode
    assign sr_local[i] = !mem_mode && sr_h0 && cfg_q[CFG_SREN + i];
    assign force_init[i] = global_init_net || sr_local[i];
    assign st_d[i] = force_init[i] ? set_cfg[i] : (ec ? st_din[i] : st_q[i]);
    // Visible at once, not only after the next edge
    assign st_vis[i] = force_init[i] ? set_cfg[i] : st_q[i];
    assign reg_out[i] = cfg_q[CFG_BYP + i] ?
                        pick4(cell_ctrl_pins, cfg_q[CFG_BSRC + 2*i +: 2]) : st_vis[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign first_registered_out = reg_out[0];
  assign second_registered_out = reg_out[1];
  assign stat_w = {24'h000000, h_gen_out, g_gen_out, f_gen_out, global_init_net,
                   reg_out[1], reg_out[0], st_vis[1], st_vis[0]};

  //////////////////////////////////////////////////////////////////////
  // Checks

  chk_global_init: assert property (global_init_net |-> st_vis == set_cfg)
    else $error("global init did not force configured state");
  chk_local_sr: assert property (sr_local[1] |-> st_vis[1] == set_cfg[1])
    else $error("local set/reset not applied at once");
  chk_sr_persist: assert property (force_init[0] |=> st_q[0] == $past(set_cfg[0]))
    else $error("storage did not settle to init value");
  chk_ce_load: assert property ((ec && !force_init[0]) |=> st_q[0] == $past(st_din[0]))
    else $error("enabled edge did not load selected data");
  chk_ce_hold: assert property ((!ec && !force_init[1]) |=> $stable(st_q[1]))
    else $error("storage changed without clock enable");
  chk_bypass_out: assert property (cfg_q[CFG_BYP] |->
      first_registered_out == cell_ctrl_pins[cfg_q[CFG_BSRC +: 2]])
    else $error("bypass output mismatch");
  chk_mem_no_sr: assert property (mem_mode |-> sr_local == 2'b00)
    else $error("local set/reset active in memory mode");
  chk_ram32_addr: assert property ((mem_mode && org32) |->
      lut_if.f_addr == lut_if.g_addr)
    else $error("32x1 tables addressed differently");
  chk_ram_write: assert property ((lut_if.we_f && !lut_if.sw_we) |=>
      lut_if.f_bits[$past(f_gen_addr)] == $past(din_h2))
    else $error("table write lost");
  chk_gsr_pin: assert property ((gsrc == GSRC_PIN && !init_q[INIT_SW]) |->
      global_init_net == (global_init_pin ^ init_q[INIT_INV]))
    else $error("pin path to global init wrong");
  chk_gsr_node: assert property ((gsrc == GSRC_H && !init_q[INIT_SW]) |->
      global_init_net == h_gen_out)
    else $error("internal node path to global init wrong");
  chk_bus_resp: assert property (do_write |=> s_axi_bvalid)
    else $error("write response missing");

  cov_local_sr: cover property (sr_local[0] ##1 !sr_local[0]);
  cov_ram32_write: cover property (mem_mode && org32 && lut_if.we_g);
  cov_dual_write: cover property (mem_mode && dual && ram_wr);
  cov_global_init: cover property (global_init_net ##1 !global_init_net);

endmodule // lcs_cell_top

/* File: lcs_lut_if.sv */
// Signals between cell control and the lookup table memory
`timescale 1ns/1ps
interface lcs_lut_if;
  logic [3:0] f_addr;
  logic [3:0] g_addr;
  logic we_f;
  logic we_g;
  logic wd_f;
  logic wd_g;
  logic sw_we;
  logic [31:0] sw_wdata;
  logic f_rd;
  logic g_rd;
  logic [15:0] f_bits;
  logic [15:0] g_bits;

  modport ctl (
    output f_addr, g_addr, we_f, we_g, wd_f, wd_g, sw_we, sw_wdata,
    input f_rd, g_rd, f_bits, g_bits
  );
  modport mem (
    input f_addr, g_addr, we_f, we_g, wd_f, wd_g, sw_we, sw_wdata,
    output f_rd, g_rd, f_bits, g_bits
  );
endinterface

/* File: lcs_lut_ram.sv */
// Two sixteen-entry lookup tables, writable by software and by the cell
`timescale 1ns/1ps
module lcs_lut_ram (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Table access
  lcs_lut_if.mem lut
);
  import lcs_pkg::*;

  logic [15:0] tab_q [2];
  logic [15:0] f_d;
  logic [15:0] g_d;

  // Cell write lands after a software write of the same cycle
  always_comb begin
    f_d = lut.sw_we ? lut.sw_wdata[15:0] : tab_q[0];
    g_d = lut.sw_we ? lut.sw_wdata[31:16] : tab_q[1];
    if (lut.we_f) begin
      f_d[lut.f_addr] = lut.wd_f;
    end
    if (lut.we_g) begin
      g_d[lut.g_addr] = lut.wd_g;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tab_q[0] <= 16'h0000;
      tab_q[1] <= 16'h0000;
    end else begin
      tab_q[0] <= f_d;
      tab_q[1] <= g_d;
    end
  end

  assign lut.f_rd = tab_q[0][lut.f_addr];
  assign lut.g_rd = tab_q[1][lut.g_addr];
  assign lut.f_bits = tab_q[0];
  assign lut.g_bits = tab_q[1];

endmodule // lcs_lut_ram

/* File: lcs_pkg.sv */
// Shared constants for the logic cell storage and control block
package lcs_pkg;

  // Bus geometry
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MAP = 8'h04;
  localparam logic [7:0] OFF_LUT = 8'h08;
  localparam logic [7:0] OFF_INIT = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;

  // Configuration register fields
  localparam int unsigned CFG_MEM = 0;
  localparam int unsigned CFG_RAM_MODE = 1;
  localparam int unsigned CFG_RAM_ORG = 3;
  localparam int unsigned CFG_SET = 5;
  localparam int unsigned CFG_SREN = 7;
  localparam int unsigned CFG_DSEL = 9;
  localparam int unsigned CFG_BYP = 13;
  localparam int unsigned CFG_BSRC = 15;
  localparam logic [31:0] CFG_MASK = 32'h0007_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0180;

  // Control pin mapping: two bits per internal signal
  localparam int unsigned MAP_EC = 0;
  localparam int unsigned MAP_SR = 1;
  localparam int unsigned MAP_DIN = 2;
  localparam int unsigned MAP_H1 = 3;
  localparam logic [31:0] MAP_MASK = 32'h0000_00ff;
  localparam logic [31:0] MAP_RESET = 32'h0000_00e4;

  // Third generator table and global init control
  localparam int unsigned INIT_HTAB = 0;
  localparam int unsigned INIT_SRC = 8;
  localparam int unsigned INIT_INV = 10;
  localparam int unsigned INIT_SW = 11;
  localparam logic [31:0] INIT_MASK = 32'h0000_0fff;
  localparam logic [31:0] INIT_RESET = 32'h0000_0000;

  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RAM_LEVEL = 2'b00, RAM_EDGE = 2'b01, RAM_DUAL = 2'b10, RAM_RSVD = 2'b11
  } lcs_ram_mode_t;
  typedef enum logic [1:0] {
    ORG_16X2 = 2'b00, ORG_32X1 = 2'b01, ORG_16X1 = 2'b10, ORG_RSVD = 2'b11
  } lcs_ram_org_t;
  typedef enum logic [1:0] {
    DSEL_F = 2'b00, DSEL_G = 2'b01, DSEL_H = 2'b10, DSEL_DIN = 2'b11
  } lcs_dsel_t;
  typedef enum logic [1:0] {
    GSRC_PIN = 2'b00, GSRC_F = 2'b01, GSRC_G = 2'b10, GSRC_H = 2'b11
  } lcs_gsrc_t;

endpackage

/* File: tb.sv */
// Self-checking testbench for the logic cell storage and control block
`timescale 1ns/1ps
module tb;
  import lcs_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] pins, faddr, gaddr;
  logic gpin, q0, q1, fo, go, ho, gnet;
  int fail_count, n_tests;
  logic [31:0] isel [4] = '{32'h100, 32'h200, 32'h300, 32'h3ff};

  lcs_cell_top lcs_cell_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cell_ctrl_pins(pins), .f_gen_addr(faddr),
    .g_gen_addr(gaddr), .global_init_pin(gpin), .first_registered_out(q0),
    .second_registered_out(q1), .f_gen_out(fo), .g_gen_out(go), .h_gen_out(ho),
    .global_init_net(gnet)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Handshake levels move only at edges, so a look 1 ns after one holds at the next
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      #1;
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid & bready;
      resp = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      fail_count++;
      report_and_stop();
    end
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hs, r_hs;
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      #1;
      ar_hs = arvalid & arready;
      r_hs = rvalid & rready;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      fail_count++;
      report_and_stop();
    end
    chk("rresp", {30'h0, er}, {30'h0, resp});
    chk("rdata", ed, rd);
  endtask

  task automatic drive(input logic [3:0] v);
    @(posedge aclk);
    pins <= v;
    #1;
  endtask

  task automatic tick;
    @(posedge aclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {pins, faddr, gaddr, gpin} = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, masking and refused places
    rdchk(OFF_CFG, CFG_RESET, RESP_OKAY);
    rdchk(OFF_MAP, MAP_RESET, RESP_OKAY);
    rdchk(OFF_INIT, INIT_RESET, RESP_OKAY);
    rdchk(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_STAT, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_CFG, 32'hffff_ffff, RESP_OKAY);
    rdchk(OFF_CFG, CFG_MASK, RESP_OKAY);
    // Data source selection, every code
    wr(OFF_LUT, 32'h0000_ffff, RESP_OKAY);
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CFG, 32'(32'h180 | (d << 9) | (d << 11)), RESP_OKAY);
      drive(4'b0101);
      tick();
      chkb("dsel_q0", 1'(4'b1001 >> d), q0);
      chkb("dsel_q1", 1'(4'b1001 >> d), q1);
    end
    // Hold without clock enable, local override still immediate
    drive(4'b0000);
    tick();
    chkb("hold_q0", 1'b1, q0);
    drive(4'b0010);
    chkb("sr_q0", 1'b0, q0);
    chkb("sr_q1", 1'b0, q1);
    drive(4'b0000);
    tick();
    chkb("sr_hold", 1'b0, q0);
    // el0 set polarity, el1 local input disabled
    wr(OFF_CFG, 32'h1ea0, RESP_OKAY);
    drive(4'b0001);
    tick();
    drive(4'b0010);
    chkb("set_q0", 1'b1, q0);
    chkb("dis_q1", 1'b0, q1);
    // Global force: el0 set, el1 reset, loaded opposite first
    wr(OFF_CFG, 32'h07a0, RESP_OKAY);
    drive(4'b0001);
    tick();
    chkb("pre_q0", 1'b0, q0);
    chkb("pre_q1", 1'b1, q1);
    wr(OFF_INIT, 32'h800, RESP_OKAY);
    chkb("gnet", 1'b1, gnet);
    chkb("gsr_q0", 1'b1, q0);
    chkb("gsr_q1", 1'b0, q1);
    drive(4'b0000);
    wr(OFF_INIT, 32'h0, RESP_OKAY);
    tick();
    chkb("after_q0", 1'b1, q0);
    chkb("after_q1", 1'b0, q1);
    // Global net from the pin, with and without inversion
    for (int i = 0; i < 4; i++) begin
      wr(OFF_INIT, 32'((i >> 1) << 10), RESP_OKAY);
      @(posedge aclk);
      gpin <= i[0];
      #1;
      chkb("gpin", i[0] ^ i[1], gnet);
    end
    @(posedge aclk);
    gpin <= 1'b0;
    // Global net from internal generator nodes
    for (int i = 0; i < 4; i++) begin
      wr(OFF_INIT, isel[i], RESP_OKAY);
      tick();
      chkb("gnode", 1'(4'b1001 >> i), gnet);
      chkb("h_out", (i == 3), ho);
    end
    wr(OFF_INIT, 32'h0, RESP_OKAY);
    // Bypass to each control pin
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CFG, 32'(32'h6000 | (k << 15) | (k << 17)), RESP_OKAY);
      drive(4'(1 << k));
      chkb("byp_q0", 1'b1, q0);
      chkb("byp_q1", 1'b1, q1);
      drive(~4'(1 << k));
      chkb("byp_lo", 1'b0, q0);
    end
    // Clock enable moved to pin 3
    wr(OFF_MAP, 32'he7, RESP_OKAY);
    wr(OFF_CFG, 32'h1f80, RESP_OKAY);
    drive(4'b1000);
    tick();
    chkb("map_a", 1'b0, q0);
    drive(4'b0101);
    tick();
    chkb("map_b", 1'b0, q0);
    drive(4'b1100);
    tick();
    chkb("map_c", 1'b1, q0);
    wr(OFF_MAP, MAP_RESET, RESP_OKAY);
    // Level mode 16x2: write a zero into F
    drive(4'b0000);
    wr(OFF_CFG, 32'h1, RESP_OKAY);
    faddr <= 4'h5;
    drive(4'b0010);
    drive(4'b0000);
    chkb("lvl_f", 1'b0, fo);
    rdchk(OFF_LUT, 32'h0000_ffdf, RESP_OKAY);
    // 32x1: fifth address bit picks G
    wr(OFF_CFG, 32'h9, RESP_OKAY);
    faddr <= 4'h6;
    drive(4'b1000);
    chkb("org_g", 1'b0, fo);
    drive(4'b0000);
    chkb("org_f", 1'b1, fo);
    drive(4'b1110);
    drive(4'b1000);
    chkb("org_wr", 1'b1, fo);
    rdchk(OFF_LUT, 32'h0040_ffdf, RESP_OKAY);
    // Edge mode needs clock enable
    wr(OFF_CFG, 32'h3, RESP_OKAY);
    faddr <= 4'h7;
    drive(4'b0010);
    drive(4'b0000);
    chkb("edge_noce", 1'b1, fo);
    drive(4'b0011);
    drive(4'b0000);
    chkb("edge_ce", 1'b0, fo);
    // Dual port: write lands in G, read on the second address
    wr(OFF_CFG, 32'h5, RESP_OKAY);
    faddr <= 4'h8;
    gaddr <= 4'h8;
    drive(4'b0111);
    drive(4'b0000);
    chkb("dual_g", 1'b1, go);
    gaddr <= 4'h0;
    tick();
    chkb("dual_rd", 1'b0, go);
    rdchk(OFF_STAT, 32'h0000_002f, RESP_OKAY);
    // 16x1 organisation also mirrors cell writes into G
    wr(OFF_CFG, 32'h13, RESP_OKAY);
    faddr <= 4'h5;
    gaddr <= 4'h5;
    drive(4'b0111);
    drive(4'b0000);
    chkb("org16_g", 1'b1, go);
    rdchk(OFF_LUT, 32'h0160_ff7f, RESP_OKAY);
    report_and_stop();
  end
endmodule // tb
